/* File: design/spc_pkg.sv */
// Constants and carrier types for the serial port control and status block.
package spc_pkg;
    // ****************************************
    // Sizes
    // ****************************************
    localparam int NCH = 2;
    localparam int AW = 18;
    // ****************************************
    // Register indexes (byte address is four times the index)
    // ****************************************
    localparam logic [15:0] IDX_FMT1 = 16'hfed8;
    localparam logic [15:0] IDX_CTRL1 = 16'hfeda;
    localparam logic [15:0] IDX_FLAG1 = 16'hfedc;
    localparam logic [15:0] IDX_FMT2 = 16'hfef0;
    localparam logic [15:0] IDX_CTRL2 = 16'hfef2;
    localparam logic [15:0] IDX_FLAG2 = 16'hfef4;
    // Register kinds returned by the decoder.
    localparam logic [1:0] K_FMT = 2'h0;
    localparam logic [1:0] K_CTRL = 2'h1;
    localparam logic [1:0] K_FLAG = 2'h2;
    // ****************************************
    // Reset values and masks
    // ****************************************
    localparam logic [7:0] FMT_RST = 8'h04;
    localparam logic [7:0] CTRL_RST = 8'h0c;
    localparam logic [7:0] FLAG_RST = 8'h87;
    localparam logic [7:0] FMT_RSV = 8'h04;
    localparam logic [7:0] CTRL_RSV = 8'h0c;
    localparam logic [7:0] FLAG_RSV = 8'h07;
    localparam logic [7:0] FLAG_LIVE = 8'hf8;
    // ****************************************
    // Field positions
    // ****************************************
    localparam int F_SYNC = 7;
    localparam int F_CHR = 6;
    localparam int F_PE = 5;
    localparam int F_ODD = 4;
    localparam int C_TXIE = 7;
    localparam int C_RXIE = 6;
    localparam int C_TXON = 5;
    localparam int C_RXON = 4;
    localparam int C_EXT = 1;
    localparam int C_CKO = 0;
    localparam int S_TXE = 7;
    localparam int S_RXF = 6;
    localparam int S_OVR = 5;
    localparam int S_FRM = 4;
    localparam int S_PAR = 3;
    // ****************************************
    // Prescaler tick masks and bus answers
    // ****************************************
    localparam logic [5:0] PRE_M1 = 6'h00;
    localparam logic [5:0] PRE_M4 = 6'h03;
    localparam logic [5:0] PRE_M16 = 6'h0f;
    localparam logic [5:0] PRE_M64 = 6'h3f;
    localparam logic [1:0] RESP_OK = 2'h0;
    localparam logic [1:0] RESP_ERR = 2'h2;
    // ****************************************
    // Carrier types
    // ****************************************
    typedef struct packed {
        logic done;
        logic [7:0] data;
        logic par_bit;
        logic stop_bit;
    } spc_rx_ev_t;
    typedef struct packed {
        logic tx_load;
        logic dtc_tx_wr;
        logic dtc_rx_rd;
    } spc_xfer_ev_t;
    typedef struct packed {
        logic tx_empty_irq;
        logic rx_full_irq;
        logic rx_error_irq;
        logic tx_pin_on;
        logic rx_pin_on;
        logic sck_o;
        logic sck_oe_n;
        logic clk_tick;
        logic [7:0] fmt;
    } spc_chan_out_t;
endpackage : spc_pkg

/* File: design/spc_serial_port_control_status.sv */
// Control, status, prescaler and pin steering for two serial channels.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module spc_serial_port_control_status (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic standby,
    input wire logic [spc_pkg::AW-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [spc_pkg::AW-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [spc_pkg::NCH-1:0] sck_pin_i,
    input wire logic [spc_pkg::NCH-1:0] sck_drive,
    input spc_pkg::spc_rx_ev_t [spc_pkg::NCH-1:0] rx_ev,
    input spc_pkg::spc_xfer_ev_t [spc_pkg::NCH-1:0] xfer_ev,
    output spc_pkg::spc_chan_out_t [spc_pkg::NCH-1:0] chan_out
);
    import spc_pkg::*;

    // ****************************************
    // Storage
    // ****************************************
    logic [7:0] fmt [NCH];
    logic [7:0] ctrl [NCH];
    logic [7:0] flag [NCH];
    logic [7:0] armed [NCH];
    logic [7:0] next_flag [NCH];
    logic [7:0] next_arm [NCH];
    logic te_off [NCH];
    logic rx_take [NCH];
    logic [5:0] pre_cnt;
    logic [NCH-1:0] sck_s1;
    logic [NCH-1:0] sck_s2;
    logic [NCH-1:0] sck_s3;
    logic aw_go;
    logic ar_go;
    logic wr_fire;
    logic rd_fire;
    logic [3:0] wdec;
    logic [3:0] rdec;
    logic [31:0] rd_val;

    // Decoder result is {hit, channel, kind}.
    function automatic logic [3:0] dec(input logic [AW-1:0] a);
        logic [15:0] idx;
        idx = a[AW-1:2];
        if (idx == IDX_FMT1) begin
            dec = {1'b1, 1'b0, K_FMT};
        end else if (idx == IDX_CTRL1) begin
            dec = {1'b1, 1'b0, K_CTRL};
        end else if (idx == IDX_FLAG1) begin
            dec = {1'b1, 1'b0, K_FLAG};
        end else if (idx == IDX_FMT2) begin
            dec = {1'b1, 1'b1, K_FMT};
        end else if (idx == IDX_CTRL2) begin
            dec = {1'b1, 1'b1, K_CTRL};
        end else if (idx == IDX_FLAG2) begin
            dec = {1'b1, 1'b1, K_FLAG};
        end else begin
            dec = 4'h0;
        end
    endfunction : dec

    // ****************************************
    // AXI4-Lite slave
    // ****************************************
    // Address and data are taken together, one transfer at a time.
    assign aw_go = s_axi_awvalid & s_axi_wvalid & ~s_axi_awready & ~s_axi_bvalid;
    assign ar_go = s_axi_arvalid & ~s_axi_arready & ~s_axi_rvalid;
    assign wr_fire = s_axi_awready;
    assign rd_fire = s_axi_arready;
    assign wdec = dec(s_axi_awaddr);
    assign rdec = dec(s_axi_araddr);

    // Write channel handshakes and response.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OK;
        end else begin
            s_axi_awready <= aw_go;
            s_axi_wready <= aw_go;
            if (wr_fire) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wdec[3] ? RESP_OK : RESP_ERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // Read mux; unmapped addresses read zero.
    always_comb begin
        rd_val = 32'h0;
        if (rdec[3]) begin
            if (rdec[1:0] == K_FMT) begin
                rd_val = {24'h0, fmt[rdec[2]]};
            end else if (rdec[1:0] == K_CTRL) begin
                rd_val = {24'h0, ctrl[rdec[2]]};
            end else begin
                rd_val = {24'h0, flag[rdec[2]]};
            end
        end
    end

    // Read channel handshakes and data.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= RESP_OK;
        end else begin
            s_axi_arready <= ar_go;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata <= rd_val;
                s_axi_rresp <= rdec[3] ? RESP_OK : RESP_ERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ****************************************
    // Format and control registers
    // ****************************************
    // Standby reloads both like reset; reserved bits are forced to one.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                fmt[c] <= FMT_RST;
                ctrl[c] <= CTRL_RST;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (standby) begin
                    fmt[c] <= FMT_RST;
                    ctrl[c] <= CTRL_RST;
                end else if (wr_fire && wdec[3] && wdec[2] == c[0] && s_axi_wstrb[0]) begin
                    if (wdec[1:0] == K_FMT) begin
                        fmt[c] <= s_axi_wdata[7:0] | FMT_RSV;
                    end else if (wdec[1:0] == K_CTRL) begin
                        ctrl[c] <= s_axi_wdata[7:0] | CTRL_RSV;
                    end
                end
            end
        end
    end

    // ****************************************
    // Status flags
    // ****************************************
    // Hardware sets are applied last so a set beats a clear in one cycle.
    always_comb begin
        for (int c = 0; c < NCH; c++) begin
            logic wsel;
            logic bad_par;
            logic frm;
            logic [7:0] chr;
            logic [7:0] clr;
            logic [7:0] set;
            wsel = wr_fire && wdec[3] && wdec[2] == c[0] && s_axi_wstrb[0];
            chr = rx_ev[c].data;
            if (fmt[c][F_CHR]) begin
                chr[7] = 1'b0;
            end
            // Parity only counts in async mode with parity enabled.
            bad_par = fmt[c][F_PE] && !fmt[c][F_SYNC]
                && ((^chr ^ rx_ev[c].par_bit) != fmt[c][F_ODD]);
            rx_take[c] = rx_ev[c].done && ctrl[c][C_RXON];
            frm = rx_take[c] && !rx_ev[c].stop_bit;
            te_off[c] = wsel && wdec[1:0] == K_CTRL
                && ctrl[c][C_TXON] && !s_axi_wdata[C_TXON];
            clr = 8'h00;
            if (wsel && wdec[1:0] == K_FLAG) begin
                clr = armed[c] & ~s_axi_wdata[7:0] & FLAG_LIVE;
            end
            clr[S_TXE] = clr[S_TXE] | xfer_ev[c].dtc_tx_wr;
            clr[S_RXF] = clr[S_RXF] | xfer_ev[c].dtc_rx_rd;
            set = 8'h00;
            set[S_TXE] = xfer_ev[c].tx_load | te_off[c];
            set[S_RXF] = rx_take[c] && !frm && !(rx_take[c] && bad_par)
                && !flag[c][S_RXF];
            set[S_OVR] = rx_take[c] && flag[c][S_RXF];
            set[S_FRM] = frm;
            set[S_PAR] = rx_take[c] && bad_par;
            next_flag[c] = (flag[c] & ~clr) | set | FLAG_RSV;
            next_arm[c] = armed[c];
            if (rd_fire && rdec[3] && rdec[2] == c[0] && rdec[1:0] == K_FLAG) begin
                next_arm[c] = armed[c] | flag[c];
            end
            next_arm[c] = next_arm[c] & next_flag[c] & FLAG_LIVE;
        end
    end

    // Flag and read-arm state.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            for (int c = 0; c < NCH; c++) begin
                flag[c] <= FLAG_RST;
                armed[c] <= 8'h00;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                if (standby) begin
                    flag[c] <= FLAG_RST;
                    armed[c] <= 8'h00;
                end else begin
                    flag[c] <= next_flag[c];
                    armed[c] <= next_arm[c];
                end
            end
        end
    end

    // ****************************************
    // Prescaler and clock pin input
    // ****************************************
    // One free counter serves both channels; ticks differ only by mask.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            pre_cnt <= 6'h00;
        end else begin
            pre_cnt <= pre_cnt + 6'h01;
        end
    end

    // The clock pin is asynchronous; s3 serves only edge detection.
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            sck_s1 <= '0;
            sck_s2 <= '0;
            sck_s3 <= '0;
        end else begin
            sck_s1 <= sck_pin_i;
            sck_s2 <= sck_s1;
            sck_s3 <= sck_s2;
        end
    end

    // ****************************************
    // Registered channel outputs
    // ****************************************
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            chan_out <= '0;
            for (int c = 0; c < NCH; c++) begin
                chan_out[c].sck_oe_n <= 1'b1;
                chan_out[c].fmt <= FMT_RST;
            end
        end else begin
            for (int c = 0; c < NCH; c++) begin
                logic [5:0] m;
                logic eflag;
                case (fmt[c][1:0])
                    2'b00: m = PRE_M1;
                    2'b01: m = PRE_M4;
                    2'b10: m = PRE_M16;
                    default: m = PRE_M64;
                endcase
                eflag = flag[c][S_OVR] | flag[c][S_FRM] | flag[c][S_PAR];
                chan_out[c].tx_empty_irq <= ctrl[c][C_TXIE] & flag[c][S_TXE];
                chan_out[c].rx_full_irq <= ctrl[c][C_RXIE] & flag[c][S_RXF];
                chan_out[c].rx_error_irq <= ctrl[c][C_RXIE] & eflag;
                chan_out[c].tx_pin_on <= ctrl[c][C_TXON];
                chan_out[c].rx_pin_on <= ctrl[c][C_RXON];
                chan_out[c].sck_o <= sck_drive[c];
                // Driving the pin needs sync mode and the internal clock.
                chan_out[c].sck_oe_n <= !(fmt[c][F_SYNC] && !ctrl[c][C_EXT]
                    && ctrl[c][C_CKO]);
                if (ctrl[c][C_EXT]) begin
                    chan_out[c].clk_tick <= sck_s2[c] & ~sck_s3[c];
                end else begin
                    chan_out[c].clk_tick <= (pre_cnt & m) == 6'h00;
                end
                chan_out[c].fmt <= fmt[c];
            end
        end
    end

    // ****************************************
    // Assertions on channel one
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    logic wr_flag0, wr_ctrl0;
    assign wr_flag0 = wr_fire && wdec == {1'b1, 1'b0, K_FLAG} && s_axi_wstrb[0];
    assign wr_ctrl0 = wr_fire && wdec == {1'b1, 1'b0, K_CTRL} && s_axi_wstrb[0];

    property p_rsv;
        fmt[0][2] && (&ctrl[0][3:2]) && (&flag[0][2:0]);
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bit lost");

    property p_pre16;
        (!ctrl[0][C_EXT] && fmt[0][1:0] == 2'b10 && pre_cnt == 6'h10 && !wr_fire && !standby)
            |=> chan_out[0].clk_tick ##1 !chan_out[0].clk_tick;
    endproperty
    a_pre16: assert property (p_pre16) else $error("prescaler tick wrong");

    property p_std;
        standby |=> ctrl[0] == CTRL_RST && flag[0] == FLAG_RST;
    endproperty
    a_std: assert property (p_std) else $error("standby init wrong");

    property p_txirq;
        (!ctrl[0][C_TXIE] || !flag[0][S_TXE]) |=> !chan_out[0].tx_empty_irq;
    endproperty
    a_txirq: assert property (p_txirq) else $error("tx irq not gated");

    property p_rxirq;
        !ctrl[0][C_RXIE] |=> !chan_out[0].rx_full_irq && !chan_out[0].rx_error_irq;
    endproperty
    a_rxirq: assert property (p_rxirq) else $error("rx irq not gated");

    property p_txpin;
        (wr_ctrl0 && s_axi_wdata[C_TXON] && !standby) |=> ##1 chan_out[0].tx_pin_on;
    endproperty
    a_txpin: assert property (p_txpin) else $error("tx pin not claimed");

    property p_ext;
        ctrl[0][C_EXT] |=> chan_out[0].sck_oe_n;
    endproperty
    a_ext: assert property (p_ext) else $error("clock pin driven");

    property p_one_keeps;
        (wr_flag0 && s_axi_wdata[S_TXE] && flag[0][S_TXE] && !standby
            && !xfer_ev[0].dtc_tx_wr) |=> flag[0][S_TXE];
    endproperty
    a_one_keeps: assert property (p_one_keeps) else $error("write one cleared");

    property p_load;
        (xfer_ev[0].tx_load && !standby) |=> flag[0][S_TXE];
    endproperty
    a_load: assert property (p_load) else $error("tx empty not set");

    property p_ovr;
        (rx_take[0] && flag[0][S_RXF] && !standby && !xfer_ev[0].dtc_rx_rd && !wr_flag0)
            |=> flag[0][S_OVR] && flag[0][S_RXF];
    endproperty
    a_ovr: assert property (p_ovr) else $error("overrun missed");

    property p_frm;
        (rx_take[0] && !rx_ev[0].stop_bit && !standby) |=> flag[0][S_FRM];
    endproperty
    a_frm: assert property (p_frm) else $error("framing missed");

    property p_c_tick;
        chan_out[0].clk_tick ##1 chan_out[0].clk_tick;
    endproperty
    c_tick: cover property (p_c_tick);

    property p_c_ovr;
        rx_take[0] && flag[0][S_RXF];
    endproperty
    c_ovr: cover property (p_c_ovr);

    property p_c_clr;
        wr_flag0 && armed[0][S_TXE] && !s_axi_wdata[S_TXE];
    endproperty
    c_clr: cover property (p_c_clr);
endmodule : spc_serial_port_control_status

/* File: tb/spc_remote_model.sv */
// Behavioural model of the remote serial device on both channels.
`timescale 1ns/10ps
module spc_remote_model (
    input wire logic core_clk,
    output spc_pkg::spc_rx_ev_t [spc_pkg::NCH-1:0] rx_ev,
    output logic [spc_pkg::NCH-1:0] sck_pin_i
);
    import spc_pkg::*;

    // Lines start quiet and the clock stands low outside bursts.
    initial begin
        rx_ev = '0;
        sck_pin_i = '0;
    end

    // One character ends per call.
    // Afterwards the lines show inverted data, so a stale value can never match.
    task automatic send(input int c, input logic [7:0] d, input logic p, input logic s);
        @(posedge core_clk);
        rx_ev[c] <= '{done: 1'b1, data: d, par_bit: p, stop_bit: s};
        @(posedge core_clk);
        rx_ev[c] <= '{done: 1'b0, data: ~d, par_bit: ~p, stop_bit: ~s};
    endtask : send

    // External clock of n periods, four core cycles each.
    task automatic burst(input int c, input int n);
        repeat (n) begin
            @(posedge core_clk);
            sck_pin_i[c] <= 1'b1;
            repeat (2) @(posedge core_clk);
            sck_pin_i[c] <= 1'b0;
            @(posedge core_clk);
        end
    endtask : burst
endmodule : spc_remote_model

/* File: tb/spc_serial_port_control_status_tb_top.sv */
// Self-checking testbench of the serial port control and status block.
`timescale 1ns/10ps
`define CHK(n, e, s) begin compares++; if ((s) !== (e)) begin miscompares++; \
    $display("[ERR] %s exp %h got %h", n, e, s); end end
module spc_serial_port_control_status_tb_top;
    import spc_pkg::*;
    logic core_clk = 1'b0, rst = 1'b1, standby = 1'b0;
    logic [AW-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_arvalid = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, v;
    logic [1:0] s_axi_bresp, s_axi_rresp, resp;
    logic [NCH-1:0] sck_pin_i, sck_drive = '0;
    spc_rx_ev_t [NCH-1:0] rx_ev;
    spc_xfer_ev_t [NCH-1:0] xfer_ev = '0;
    spc_chan_out_t [NCH-1:0] chan_out;
    int miscompares = 0, compares = 0, cycles = 0, n;

    // ****************************************
    // Clock, watchdog and instances
    // ****************************************
    always #10 core_clk = ~core_clk;
    // The whole run needs about 530 cycles, so 20000 means a hang.
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 20000) begin
            miscompares++;
            results();
        end
    end
    spc_remote_model remote_u (.core_clk(core_clk), .rx_ev(rx_ev), .sck_pin_i(sck_pin_i));
    spc_serial_port_control_status dut_u (.core_clk(core_clk), .rst(rst), .standby(standby),
        .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
        .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(4'h1),
        .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
        .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(1'b1), .s_axi_araddr(s_axi_araddr),
        .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
        .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
        .s_axi_rready(1'b1), .sck_pin_i(sck_pin_i), .sck_drive(sck_drive), .rx_ev(rx_ev),
        .xfer_ev(xfer_ev), .chan_out(chan_out));

    // ****************************************
    // Bus and helper tasks
    // ****************************************
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
    endtask : cyc
    // Both ready lines are held high, which keeps back-to-back calls free of races.
    task automatic wr(input logic [15:0] i, input logic [7:0] d);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_awready !== 1'b1);
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_bvalid !== 1'b1);
        resp = s_axi_bresp;
    endtask : wr
    task automatic rd(input logic [15:0] i);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1'b1;
        do @(posedge core_clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge core_clk); while (s_axi_rvalid !== 1'b1);
        v = s_axi_rdata;
        resp = s_axi_rresp;
    endtask : rd
    task automatic rchk(input string nm, input logic [15:0] i, input logic [7:0] e);
        rd(i);
        `CHK(nm, {24'h0, e}, v)
    endtask : rchk
    // Pulse of the transfer controller events on channel 1.
    task automatic xp(input spc_xfer_ev_t e);
        xfer_ev[0] <= e;
        @(posedge core_clk);
        xfer_ev[0] <= '0;
        cyc(2);
    endtask : xp

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rchk("ctrl1", IDX_CTRL1, 8'h0c);
        rchk("flag1", IDX_FLAG1, 8'h87);
        rchk("fmt1", IDX_FMT1, 8'h04);
        rchk("ctrl2", IDX_CTRL2, 8'h0c);
        rchk("flag2", IDX_FLAG2, 8'h87);
        `CHK("oe_n", 1'b1, chan_out[0].sck_oe_n)
    endtask : t_reset
    // Reserved bits stay one and written ones never set a flag.
    task automatic t_reserved;
        wr(IDX_CTRL1, 8'h00);
        rchk("ctrl1", IDX_CTRL1, 8'h0c);
        wr(IDX_FMT1, 8'h00);
        rchk("fmt1", IDX_FMT1, 8'h04);
        wr(IDX_FLAG1, 8'hf8);
        rchk("flag1", IDX_FLAG1, 8'h87);
    endtask : t_reserved
    task automatic t_enables;
        wr(IDX_CTRL1, 8'ha0);
        wr(IDX_CTRL2, 8'ha0);
        cyc(3);
        `CHK("txpin", 1'b1, chan_out[0].tx_pin_on)
        `CHK("txirq", 1'b1, chan_out[0].tx_empty_irq)
        `CHK("txirq2", 1'b1, chan_out[1].tx_empty_irq)
        `CHK("rxpin", 1'b0, chan_out[0].rx_pin_on)
        wr(IDX_CTRL1, 8'h20);
        cyc(3);
        `CHK("txirq", 1'b0, chan_out[0].tx_empty_irq)
        wr(IDX_CTRL1, 8'h10);
        cyc(3);
        `CHK("rxpin", 1'b1, chan_out[0].rx_pin_on)
        `CHK("txpin", 1'b0, chan_out[0].tx_pin_on)
    endtask : t_enables
    // Good character, overrun, masking, and framing clear only after a read.
    task automatic t_receive;
        wr(IDX_CTRL1, 8'h50);
        remote_u.send(0, 8'h5a, 1'b0, 1'b1);
        cyc(3);
        `CHK("rxirq", 1'b1, chan_out[0].rx_full_irq)
        remote_u.send(0, 8'ha5, 1'b0, 1'b1);
        rchk("flag1", IDX_FLAG1, 8'he7);
        `CHK("errirq", 1'b1, chan_out[0].rx_error_irq)
        wr(IDX_CTRL1, 8'h10);
        cyc(3);
        `CHK("rxirq", 1'b0, chan_out[0].rx_full_irq)
        `CHK("errirq", 1'b0, chan_out[0].rx_error_irq)
        wr(IDX_FLAG1, 8'h80);
        rchk("flag1", IDX_FLAG1, 8'h87);
        remote_u.send(0, 8'h3c, 1'b0, 1'b0);
        wr(IDX_FLAG1, 8'hef);
        rchk("flag1", IDX_FLAG1, 8'h97);
        wr(IDX_FLAG1, 8'hef);
        rchk("flag1", IDX_FLAG1, 8'h87);
    endtask : t_receive
    task automatic t_dtc;
        remote_u.send(0, 8'h11, 1'b0, 1'b1);
        xp('{tx_load: 1'b0, dtc_tx_wr: 1'b0, dtc_rx_rd: 1'b1});
        rchk("flag1", IDX_FLAG1, 8'h87);
        xp('{tx_load: 1'b0, dtc_tx_wr: 1'b1, dtc_rx_rd: 1'b0});
        rchk("flag1", IDX_FLAG1, 8'h07);
        xp('{tx_load: 1'b1, dtc_tx_wr: 1'b0, dtc_rx_rd: 1'b0});
        rchk("flag1", IDX_FLAG1, 8'h87);
        xp('{tx_load: 1'b0, dtc_tx_wr: 1'b1, dtc_rx_rd: 1'b0});
        wr(IDX_CTRL1, 8'h30);
        wr(IDX_CTRL1, 8'h10);
        rchk("flag1", IDX_FLAG1, 8'h87);
        wr(IDX_FLAG1, 8'h7f);
        rchk("flag1", IDX_FLAG1, 8'h07);
        xp('{tx_load: 1'b1, dtc_tx_wr: 1'b0, dtc_rx_rd: 1'b0});
    endtask : t_dtc
    // Even parity with a wrong bit, odd parity with a matching one, then 7-bit even.
    task automatic t_parity;
        wr(IDX_FMT1, 8'h20);
        remote_u.send(0, 8'h01, 1'b0, 1'b1);
        rchk("flag1", IDX_FLAG1, 8'h8f);
        wr(IDX_FLAG1, 8'hf7);
        wr(IDX_FMT1, 8'h30);
        remote_u.send(0, 8'h01, 1'b0, 1'b1);
        rchk("flag1", IDX_FLAG1, 8'hc7);
        xp('{tx_load: 1'b0, dtc_tx_wr: 1'b0, dtc_rx_rd: 1'b1});
        wr(IDX_FMT1, 8'h60);
        remote_u.send(0, 8'h81, 1'b1, 1'b1);
        rchk("flag1", IDX_FLAG1, 8'hc7);
    endtask : t_parity
    // Any 64-cycle window holds exactly 64/N ticks, whatever the counter phase.
    task automatic t_prescale;
        for (int k = 0; k < 4; k++) begin
            wr(IDX_FMT1, 8'(k));
            cyc(4);
            n = 0;
            repeat (64) begin
                @(posedge core_clk);
                if (chan_out[0].clk_tick === 1'b1) n++;
            end
            `CHK("ticks", 64 >> (2 * k), n)
        end
    endtask : t_prescale
    task automatic t_clkpin;
        wr(IDX_FMT1, 8'h80);
        wr(IDX_CTRL1, 8'h01);
        sck_drive <= 2'b11;
        cyc(3);
        `CHK("oe_n", 1'b0, chan_out[0].sck_oe_n)
        `CHK("sck_o", 1'b1, chan_out[0].sck_o)
        wr(IDX_CTRL1, 8'h03);
        cyc(3);
        `CHK("oe_n", 1'b1, chan_out[0].sck_oe_n)
        n = 0;
        fork
            remote_u.burst(0, 5);
            repeat (30) begin
                @(posedge core_clk);
                if (chan_out[0].clk_tick === 1'b1) n++;
            end
        join
        `CHK("extticks", 5, n)
        wr(IDX_FMT1, 8'h00);
        wr(IDX_CTRL1, 8'h01);
        cyc(3);
        `CHK("oe_n", 1'b1, chan_out[0].sck_oe_n)
    endtask : t_clkpin
    task automatic t_unmapped;
        wr(16'h0100, 8'h55);
        `CHK("bresp", RESP_ERR, resp)
        rd(16'h0100);
        `CHK("rresp", RESP_ERR, resp)
        `CHK("rdata", 32'h0, v)
    endtask : t_unmapped
    task automatic t_standby;
        wr(IDX_CTRL1, 8'hf3);
        wr(IDX_FMT1, 8'hb3);
        standby <= 1'b1;
        cyc(2);
        standby <= 1'b0;
        @(posedge core_clk);
        rchk("ctrl1", IDX_CTRL1, 8'h0c);
        rchk("flag1", IDX_FLAG1, 8'h87);
        rchk("fmt1", IDX_FMT1, 8'h04);
        `CHK("fmtout", 8'h04, chan_out[0].fmt)
    endtask : t_standby

    // Verdict and end of the run.
    task automatic results;
        if (miscompares == 0 && compares > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results

    // Main sequence after four cycles of reset.
    initial begin
        repeat (4) @(posedge core_clk);
        rst <= 1'b0;
        @(posedge core_clk);
        t_reset();
        t_reserved();
        t_enables();
        t_receive();
        t_dtc();
        t_parity();
        t_prescale();
        t_clkpin();
        t_unmapped();
        t_standby();
        results();
    end
endmodule : spc_serial_port_control_status_tb_top
